/* shared/epc_consts.svh */
// Constants for the encoder position counter: parameter numbers, fields, resets.
// Assumes inclusion by bare name from the package and design files.
`ifndef EPC_CONSTS_SVH
`define EPC_CONSTS_SVH

`define EPC_AP_USTEP   8'h8c
`define EPC_AP_POS     8'hd1
`define EPC_AP_SET     8'hd2
`define EPC_AP_MAXDEV  8'hd4
`define EPC_AP_ABS     8'hd7
`define EPC_GP_SRC     8'h4a

`define EPC_FRAC_W     9
`define EPC_MAG_PMASK  32'hfffffff0
`define EPC_QUAD_PMASK 32'hffffffe0

`define EPC_B_REV      0
`define EPC_B_MAGCLR   2
`define EPC_B_APOL     0
`define EPC_B_BPOL     1
`define EPC_B_QCLR     3
`define EPC_B_NPOL     4

`define EPC_SET_RST    32'h00019000
`define EPC_USTEP_RST  4'h8
`define EPC_USTEP_MAX  4'h8
`define EPC_USRES_RST  9'h100

`endif

/* shared/epc_pkg.sv */
// Types for the encoder position counter.
// Assumes the constants header is on the include path.
package epc_pkg;
  `include "epc_consts.svh"

  typedef enum logic {
    EPC_SRC_MAG,
    EPC_SRC_QUAD
  } epc_src_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [1:0] prev;
    logic       en;
    logic       up;
  } epc_quad_st_t;

  typedef struct packed {
    logic [7:0]        ang_s1;
    logic [7:0]        ang_s2;
    logic [7:0]        ang_prev;
    logic signed [31:0] pos;
    logic [8:0]        frac;
    logic [31:0]       settings;
    logic [31:0]       maxdev;
    epc_src_t          src;
    logic [3:0]        ustep;
    logic [8:0]        usres;
    logic              null_prev;
    logic              stop;
    logic              rsp_valid;
    logic              rsp_err;
    logic [31:0]       rsp_value;
  } epc_top_st_t;
endpackage

/* shared/epc_quad_if.sv */
// Carrier between the quadrature front end and the counter core.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface epc_quad_if;
  logic a;
  logic b;
  logic n;
  logic cnt_en;
  logic cnt_up;
  modport drv (output a, output b, output n, output cnt_en, output cnt_up);
  modport mon (input a, input b, input n, input cnt_en, input cnt_up);
endinterface

/* hw/epc_quad.sv */
// Quadrature front end: synchronises A, B, null and decodes x4 counts.
// Assumes encoder pins are asynchronous to i_clk_sys.
`timescale 1ns/1ps
module epc_quad (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_enc_a,
  input  wire logic i_enc_b,
  input  wire logic i_enc_n,
  epc_quad_if.drv   q
);
  import epc_pkg::*;

  epc_quad_st_t r;
  epc_quad_st_t r_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  always_comb begin
    r_nxt      = r;
    r_nxt.s1   = {i_enc_a, i_enc_b, i_enc_n};
    r_nxt.s2   = r.s1;
    r_nxt.prev = r.s2[2:1];
    r_nxt.en   = (r.s2[2] ^ r.prev[1]) ^ (r.s2[1] ^ r.prev[0]);
    r_nxt.up   = ~(r.prev[1] ^ r.s2[1]);
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign q.a      = r.s2[2];
  assign q.b      = r.s2[1];
  assign q.n      = r.s2[0];
  assign q.cnt_en = r.en;
  assign q.cnt_up = r.up;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  quad_edge_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ($countones(r.s2[2:1] ^ r.prev) == 1) |=> q.cnt_en)
    else $error("single edge not counted");
  quad_skip_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ((r.s2[2:1] ^ r.prev) != 2'b01 && (r.s2[2:1] ^ r.prev) != 2'b10) |=> !q.cnt_en)
    else $error("count without single edge");
  quad_up_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    q.cnt_en && q.cnt_up);
endmodule

/* hw/epc_top.sv */
// Encoder position counter core with axis-parameter command port.
// Assumes commands and motor position come from logic on i_clk_sys.
//
// Overview of operation
// - Source select 0 picks magnetic encoder (reset), 1 picks external quadrature.
// - Only the selected source ever changes the position counter.
// - Magnetic encoder angle has 256 steps per shaft turn.
// - Position counter is readable and writable with any signed 32-bit value.
// - Absolute single-turn angle reads 0 to 255 regardless of prescaler.
// - Motor stop when deviation exceeds maximum; maximum 0 disables.
// - Prescaler equals settings value with low 4 (magnetic) or 5 (quadrature) bits cleared, divided by 512.
// - Each encoder count adds prescaler to the microstep-aligned position.
// - Magnetic mode value 4 clears position on each zero crossing.
// - Magnetic mode value 1 reverses counting, combinable with clear on zero crossing.
// - Settings bits 0 and 1 give A and B levels at null.
// - Value 8 clears the counter at the next null event.
// - Settings bit 4 gives the null channel level for clearing.
// - Quadrature decode yields four counts per encoder line.
// - Microstep resolution is two to the setting, setting 0 to 8.
`timescale 1ns/1ps
`include "epc_consts.svh"
module epc_top (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic [7:0]        i_mag_angle,
  input  wire logic              i_enc_a,
  input  wire logic              i_enc_b,
  input  wire logic              i_enc_n,
  input  wire logic [31:0]       i_motor_pos,
  input  wire logic              i_cmd_valid,
  input  wire logic              i_cmd_write,
  input  wire logic              i_cmd_global,
  input  wire logic [7:0]        i_cmd_param,
  input  wire logic [31:0]       i_cmd_value,
  output logic                   o_rsp_valid,
  output logic                   o_rsp_err,
  output logic [31:0]            o_rsp_value,
  output logic [31:0]            o_enc_pos,
  output logic [7:0]             o_abs_angle,
  output logic                   o_motor_stop,
  output logic [8:0]             o_ustep_res,
  output epc_pkg::epc_src_t      o_enc_src
);
  import epc_pkg::*;

  epc_top_st_t        r;
  epc_top_st_t        r_nxt;
  epc_quad_if         u_qif ();
  logic [31:0]        mpm;
  logic [31:0]        qpm;
  logic [7:0]         d8;
  logic [8:0]         d9;
  logic [9:0]         wsum;
  logic               wrap;
  logic               ncond;
  logic               nev;
  logic signed [41:0] inc;
  logic [40:0]        acc;
  logic [32:0]        diff;
  logic [32:0]        adiff;
  logic               dev_over;
  logic               wr;

  epc_quad u_quad (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_enc_a   (i_enc_a),
    .i_enc_b   (i_enc_b),
    .i_enc_n   (i_enc_n),
    .q         (u_qif.drv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counting, clearing, deviation and command handling
  always_comb begin
    r_nxt    = r;
    wr       = i_cmd_valid && i_cmd_write;
    mpm      = r.settings & `EPC_MAG_PMASK;
    qpm      = r.settings & `EPC_QUAD_PMASK;
    d8       = r.ang_s2 - r.ang_prev;
    d9       = {d8[7], d8};
    if (r.settings[`EPC_B_REV]) begin
      d9 = 9'h0 - d9;
    end
    wsum     = {2'b00, r.ang_prev} + {{2{d8[7]}}, d8};
    wrap     = (wsum[9:8] != 2'b00);
    ncond    = (u_qif.n == r.settings[`EPC_B_NPOL]) &&
               (u_qif.a == r.settings[`EPC_B_APOL]) &&
               (u_qif.b == r.settings[`EPC_B_BPOL]);
    nev      = ncond && !r.null_prev;
    inc      = 42'h0;
    if (r.src == EPC_SRC_MAG) begin
      inc = $signed({{33{d9[8]}}, d9}) * $signed({10'h0, mpm});
    end else if (u_qif.cnt_en) begin
      inc = u_qif.cnt_up ? $signed({10'h0, qpm}) : $signed(42'h0 - {10'h0, qpm});
    end
    acc      = {r.pos, r.frac} + inc[40:0];

    r_nxt.ang_s1    = i_mag_angle;
    r_nxt.ang_s2    = r.ang_s1;
    r_nxt.ang_prev  = r.ang_s2;
    r_nxt.null_prev = ncond;
    r_nxt.pos       = $signed(acc[40:`EPC_FRAC_W]);
    r_nxt.frac      = acc[`EPC_FRAC_W-1:0];
    if (r.src == EPC_SRC_MAG && r.settings[`EPC_B_MAGCLR] && wrap) begin
      r_nxt.pos  = 32'sh0;
      r_nxt.frac = 9'h0;
    end
    if (r.src == EPC_SRC_QUAD && r.settings[`EPC_B_QCLR] && nev) begin
      r_nxt.pos                   = 32'sh0;
      r_nxt.frac                  = 9'h0;
      r_nxt.settings[`EPC_B_QCLR] = 1'b0;
    end

    diff     = {r.pos[31], r.pos} - {i_motor_pos[31], i_motor_pos};
    adiff    = diff[32] ? 33'h0 - diff : diff;
    dev_over = (r.maxdev != 32'h0) && (adiff > {1'b0, r.maxdev});
    r_nxt.stop = dev_over;

    r_nxt.rsp_valid = i_cmd_valid;
    r_nxt.rsp_err   = 1'b0;
    r_nxt.rsp_value = 32'h0;
    if (i_cmd_valid && i_cmd_global) begin
      if (i_cmd_param != `EPC_GP_SRC || (wr && i_cmd_value[31:1] != 31'h0)) begin
        r_nxt.rsp_err = 1'b1;
      end else if (wr) begin
        r_nxt.src = epc_src_t'(i_cmd_value[0]);
      end else begin
        r_nxt.rsp_value = {31'h0, r.src};
      end
    end else if (i_cmd_valid) begin
      case (i_cmd_param)
        `EPC_AP_POS: begin
          r_nxt.rsp_value = r.pos;
          if (wr) begin
            r_nxt.pos  = $signed(i_cmd_value);
            r_nxt.frac = 9'h0;
          end
        end
        `EPC_AP_SET: begin
          r_nxt.rsp_value = r.settings;
          if (wr) begin
            r_nxt.settings = i_cmd_value;
          end
        end
        `EPC_AP_MAXDEV: begin
          r_nxt.rsp_value = r.maxdev;
          if (wr) begin
            r_nxt.maxdev = i_cmd_value;
          end
        end
        `EPC_AP_ABS: begin
          r_nxt.rsp_value = {24'h0, r.ang_s2};
          r_nxt.rsp_err   = wr;
        end
        `EPC_AP_USTEP: begin
          r_nxt.rsp_value = {28'h0, r.ustep};
          if (wr && i_cmd_value > {28'h0, `EPC_USTEP_MAX}) begin
            r_nxt.rsp_err = 1'b1;
          end else if (wr) begin
            r_nxt.ustep = i_cmd_value[3:0];
          end
        end
        default: begin
          r_nxt.rsp_err = 1'b1;
        end
      endcase
    end
    r_nxt.usres = 9'h1 << r_nxt.ustep;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r          <= '0;
      r.settings <= `EPC_SET_RST;
      r.ustep    <= `EPC_USTEP_RST;
      r.usres    <= `EPC_USRES_RST;
    end else begin
      r <= r_nxt;
    end
  end

  assign o_rsp_valid  = r.rsp_valid;
  assign o_rsp_err    = r.rsp_err;
  assign o_rsp_value  = r.rsp_value;
  assign o_enc_pos    = r.pos;
  assign o_abs_angle  = r.ang_s2;
  assign o_motor_stop = r.stop;
  assign o_ustep_res  = r.usres;
  assign o_enc_src    = r.src;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  rsp_timing_a: assert property (i_cmd_valid |=> o_rsp_valid ##1 !o_rsp_valid || $past(i_cmd_valid, 1))
    else $error("response not one cycle after command");
  pos_write_a: assert property (wr && !i_cmd_global && i_cmd_param == `EPC_AP_POS
    |=> o_enc_pos == $past(i_cmd_value) && !o_rsp_err)
    else $error("position write lost");
  abs_range_a: assert property (i_cmd_valid && !i_cmd_global && i_cmd_param == `EPC_AP_ABS
    |=> o_rsp_value[31:8] == 24'h0 && o_rsp_value[7:0] == $past(o_abs_angle))
    else $error("absolute angle out of range");
  dev_off_a: assert property (r.maxdev == 32'h0 |=> !o_motor_stop)
    else $error("stop with deviation check off");
  dev_stop_a: assert property (dev_over |=> o_motor_stop)
    else $error("deviation did not stop motor");
  src_excl_a: assert property (r.src == EPC_SRC_MAG && !i_cmd_valid && d8 == 8'h0
    |=> $stable(o_enc_pos))
    else $error("idle source changed position");
  src_sel_a: assert property (wr && i_cmd_global && i_cmd_param == `EPC_GP_SRC
    && i_cmd_value[31:1] == 31'h0 |=> o_enc_src == epc_src_t'($past(i_cmd_value[0])))
    else $error("source select not applied");
  ustep_res_a: assert property (wr && !i_cmd_global && i_cmd_param == `EPC_AP_USTEP
    && i_cmd_value < 32'h9 |=> o_ustep_res == (9'h1 << $past(i_cmd_value[3:0])))
    else $error("microstep resolution wrong");
  null_clr_a: assert property (r.src == EPC_SRC_QUAD && r.settings[`EPC_B_QCLR] && nev
    && !i_cmd_valid |=> o_enc_pos == 32'h0 && !r.settings[`EPC_B_QCLR])
    else $error("null event did not clear");
  mag_clr_a: assert property (r.src == EPC_SRC_MAG && r.settings[`EPC_B_MAGCLR] && wrap
    && !i_cmd_valid |=> o_enc_pos == 32'h0)
    else $error("zero crossing did not clear");
  unit_step_a: assert property (r.src == EPC_SRC_QUAD && u_qif.cnt_en && qpm == 32'h200
    && r.frac == 9'h0 && !i_cmd_valid && !(r.settings[`EPC_B_QCLR] && nev)
    |=> (o_enc_pos - $past(o_enc_pos)) == ($past(u_qif.cnt_up) ? 32'h1 : 32'hffffffff))
    else $error("unit prescaler step wrong");

  stop_c: cover property ($rose(o_motor_stop));
  nclr_c: cover property (r.src == EPC_SRC_QUAD && r.settings[`EPC_B_QCLR] && nev);
  wrap_c: cover property (r.src == EPC_SRC_MAG && wrap);
  frac_c: cover property (r.frac != 9'h0 ##1 r.frac == 9'h0 && $changed(o_enc_pos));
endmodule

/* verification/epc_enc_model.sv */
// Partner model: magnetic angle source and quadrature A/B/null pins.
// Assumes its tasks are called just after a falling clock edge.
`timescale 1ns/1ps
module epc_enc_model (
  input  wire logic       i_clk_sys,
  output logic [7:0]      o_angle,
  output logic            o_a,
  output logic            o_b,
  output logic            o_n
);
  int ph;
  initial begin
    o_angle = 8'h00;
    o_a = 1'b0;
    o_b = 1'b0;
    o_n = 1'b0;
    ph = 0;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic settle();
    repeat (6) @(negedge i_clk_sys);
  endtask
  task automatic turn(input int d);
    o_angle = o_angle + d[7:0];
    settle();
  endtask
  task automatic qstep(input bit up);
    ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
    o_a = ph[0] ^ ph[1];
    o_b = ph[1];
    settle();
  endtask
  task automatic null_lvl(input bit v);
    o_n = v;
    settle();
  endtask
endmodule

/* verification/encoder_position_counter_tb.sv */
// Self-checking bench for the encoder position counter.
// Assumes the partner model drives all encoder pins.
`timescale 1ns/1ps
`include "epc_consts.svh"
module encoder_position_counter_tb;
  import epc_pkg::*;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic [7:0]  mag;
  logic        ea;
  logic        eb;
  logic        en;
  logic [31:0] mpos;
  logic        cv   = 1'b0;
  logic        cw;
  logic        cg;
  logic [7:0]  cp;
  logic [31:0] cval;
  logic        rv;
  logic        re;
  logic [31:0] rval;
  logic [31:0] pos;
  logic [7:0]  ang;
  logic        stop;
  logic [8:0]  ures;
  epc_src_t    src;
  logic [31:0] rdat;
  logic        rerr;
  logic [31:0] v;
  logic [31:0] s;
  int          d;
  int          fail_count = 0;
  int          num_checks = 0;
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  epc_enc_model m (.i_clk_sys(clk), .o_angle(mag), .o_a(ea), .o_b(eb), .o_n(en));
  epc_top dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_mag_angle(mag), .i_enc_a(ea),
    .i_enc_b(eb), .i_enc_n(en), .i_motor_pos(mpos), .i_cmd_valid(cv),
    .i_cmd_write(cw), .i_cmd_global(cg), .i_cmd_param(cp), .i_cmd_value(cval),
    .o_rsp_valid(rv), .o_rsp_err(re), .o_rsp_value(rval), .o_enc_pos(pos),
    .o_abs_angle(ang), .o_motor_stop(stop), .o_ustep_res(ures), .o_enc_src(src)
  );
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle_junk();
    cw   = 1'($urandom);
    cg   = 1'($urandom);
    cp   = 8'($urandom);
    cval = $urandom;
  endtask
  task automatic cmd(input logic w, input logic g, input logic [7:0] p,
                     input logic [31:0] val);
    @(negedge clk);
    cv   = 1'b1;
    cw   = w;
    cg   = g;
    cp   = p;
    cval = val;
    @(negedge clk);
    cv = 1'b0;
    idle_junk();
    rdat = rval;
    rerr = re;
    chk({31'h0, rv}, 32'h1);
  endtask
  task automatic wr(input logic g, input logic [7:0] p, input logic [31:0] val,
                    input logic ee);
    cmd(1'b1, g, p, val);
    chk({31'h0, rerr}, {31'h0, ee});
  endtask
  task automatic rd(input logic g, input logic [7:0] p, input logic [31:0] x);
    cmd(1'b0, g, p, 32'h0);
    chk(rdat, x);
    chk({31'h0, rerr}, 32'h0);
  endtask
  task automatic wt();
    repeat (3) @(negedge clk);
  endtask
  // Stop expected when the position gap exceeds a non-zero limit
  function automatic logic exp_stop(input logic [31:0] p, input logic [31:0] mp,
                                    input logic [31:0] lim);
    longint read_axis_setting;
    read_axis_setting = longint'(signed'(p)) - longint'(signed'(mp));
    if (read_axis_setting < 0) begin
      read_axis_setting = -read_axis_setting;
    end
    return (lim != 32'h0) && (read_axis_setting > longint'(lim));
  endfunction
  ////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    fail_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h190a495e));
    mpos = $urandom;
    idle_junk();
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rd(1'b0, `EPC_AP_SET, 32'h00019000);
    rd(1'b1, `EPC_GP_SRC, 32'h0);
    rd(1'b0, `EPC_AP_MAXDEV, 32'h0);
    chk({23'h0, ures}, 32'h100);
    v = $urandom;
    wr(1'b0, `EPC_AP_POS, v, 1'b0);
    rd(1'b0, `EPC_AP_POS, v);
    wr(1'b0, `EPC_AP_POS, 32'h80000000, 1'b0);
    chk(pos, 32'h80000000);
    wr(1'b0, `EPC_AP_SET, 32'h200, 1'b0);
    wr(1'b0, `EPC_AP_POS, 32'h0, 1'b0);
    d = 1 + $urandom % 40;
    m.turn(d);
    chk(pos, d);
    rd(1'b0, `EPC_AP_ABS, {24'h0, m.o_angle});
    chk({24'h0, ang}, {24'h0, m.o_angle});
    wr(1'b0, `EPC_AP_ABS, 32'h0, 1'b1);
    wr(1'b0, `EPC_AP_SET, 32'h201, 1'b0);
    m.turn(3);
    chk(pos, d - 3);
    wr(1'b0, `EPC_AP_SET, 32'h100, 1'b0);
    m.turn(1);
    chk(pos, d - 3);
    m.turn(1);
    chk(pos, d - 2);
    wr(1'b0, `EPC_AP_SET, 32'h204, 1'b0);
    while (m.o_angle < 8'd150) m.turn(100);
    m.turn(60);
    chk(pos, 32'h0);
    wr(1'b1, `EPC_GP_SRC, 32'h2, 1'b1);
    wr(1'b1, `EPC_GP_SRC, 32'h1, 1'b0);
    chk({31'h0, src}, 32'h1);
    wr(1'b0, `EPC_AP_SET, 32'h400, 1'b0);
    wr(1'b0, `EPC_AP_POS, 32'h0, 1'b0);
    m.turn(30);
    chk(pos, 32'h0);
    repeat (8) m.qstep(1'b1);
    chk(pos, 32'd16);
    repeat (2) m.qstep(1'b0);
    chk(pos, 32'd12);
    s = 32'h418 | {30'h0, m.o_b, m.o_a};
    wr(1'b0, `EPC_AP_SET, s, 1'b0);
    m.null_lvl(1'b1);
    chk(pos, 32'h0);
    rd(1'b0, `EPC_AP_SET, s & 32'hfffffff7);
    m.null_lvl(1'b0);
    m.qstep(1'b1);
    chk(pos, 32'd2);
    s = 32'h418 | {30'h0, m.o_b, ~m.o_a};
    wr(1'b0, `EPC_AP_SET, s, 1'b0);
    m.null_lvl(1'b1);
    chk(pos, 32'd2);
    m.null_lvl(1'b0);
    wr(1'b0, `EPC_AP_MAXDEV, 32'd10, 1'b0);
    mpos = 32'd13;
    wt();
    chk({31'h0, stop}, {31'h0, exp_stop(32'd2, mpos, 32'd10)});
    mpos = 32'hfffffff8;
    wt();
    chk({31'h0, stop}, {31'h0, exp_stop(32'd2, mpos, 32'd10)});
    mpos = $urandom;
    wt();
    chk({31'h0, stop}, {31'h0, exp_stop(32'd2, mpos, 32'd10)});
    mpos = 32'd13;
    wr(1'b0, `EPC_AP_MAXDEV, 32'h0, 1'b0);
    wt();
    chk({31'h0, stop}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      wr(1'b0, `EPC_AP_USTEP, i, 1'b0);
      chk({23'h0, ures}, 32'h1 << i);
    end
    wr(1'b0, `EPC_AP_USTEP, 32'd9, 1'b1);
    chk({23'h0, ures}, 32'h100);
    complete_run();
  end
endmodule
